//--- rtl/timer_ctrl_regs.sv
// wishbone register block for timer enables, match flags, masks and clock stops
//
// Function
// - read-only enable bit per channel gates counting
// - enable-set bit n sets channel enable
// - enable-set bit 15 starts os timer
// - several set bits start counters together
// - enable-clear bit n stops channel n
// - enable-clear bit 15 stops os timer
// - reserved bits 14 to 6 ignored
// - half match sets flag bits 21:16
// - full match sets flag bits 5:0
// - os timer match sets flag bit 15
// - flag register read-only, reserved zero, reset zero
// - flag-set ones set matching flags
// - flag-clear ones clear matching flags
// - read-only mask bit per match source
// - mask resets with half/full sources masked
// - mask-set ones set mask bits
// - mask-clear ones clear mask bits
// - stop bit withholds clock and blocks access
// - stop bits: watchdog 16, os 15, channels
// - stop register read-only, reset zero
// - stop-set bits 16 and 15 stop units
// - stop-set bit n stops channel n
// - stop-clear ones restore unit clocks
// - three lines: os, channel 5, channels 0-4
`timescale 1ns/1ps
module timer_ctrl_regs
    import timer_regs_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [DATA_W-1:0] dat_i,
    output logic      [DATA_W-1:0] dat_o,
    input  wire logic              we_i,
    input  wire logic [SEL_W-1:0]  sel_i,
    input  wire logic              stb_i,
    input  wire logic              cyc_i,
    output logic                   ack_o,
    input  wire logic [CHAN_N-1:0] half_match_i,
    input  wire logic [CHAN_N-1:0] full_match_i,
    input  wire logic              os_match_i,
    output logic      [CHAN_N-1:0] chan_count_enable_o,
    output logic                   os_timer_count_enable_o,
    output logic      [CHAN_N-1:0] chan_clock_stop_o,
    output logic                   os_timer_clock_stop_o,
    output logic                   watchdog_clock_stop_o,
    output logic      [IRQ_N-1:0]  irq_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lane_bits(input logic [SEL_W-1:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < SEL_W; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction : lane_bits

    function automatic logic [31:0] strobe_if(input logic hit, input logic [31:0] data);
        return hit ? data : ZERO_WORD;
    endfunction : strobe_if

    // ------------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------------
    typedef struct packed {
        bus_state_type bus;
        logic          ack;
        logic [31:0]   rdata;
    } slave_state_type;

    slave_state_type state_r;
    slave_state_type state_nxt;

    logic [31:0] enable_value;
    logic [31:0] flag_value;
    logic [31:0] mask_value;
    logic [31:0] stop_value;
    logic [31:0] wdata;
    logic        wr;
    logic [31:0] enable_set;
    logic [31:0] enable_clear;
    logic [31:0] flag_set;
    logic [31:0] flag_clear;
    logic [31:0] mask_set;
    logic [31:0] mask_clear;
    logic [31:0] stop_set;
    logic [31:0] stop_clear;
    logic [31:0] match_event;
    logic [31:0] read_word;

    // ------------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------------
    // a write lands on the edge that the master sees ack, never earlier
    always_comb begin
        wr           = (state_r.bus == BUS_ACK) && cyc_i && stb_i && we_i;
        wdata        = dat_i & lane_bits(sel_i);
        enable_set   = strobe_if(wr && adr_i == OFS_ENABLE_SET, wdata);
        enable_clear = strobe_if(wr && adr_i == OFS_ENABLE_CLEAR, wdata);
        flag_set     = strobe_if(wr && adr_i == OFS_FLAG_SET, wdata);
        flag_clear   = strobe_if(wr && adr_i == OFS_FLAG_CLEAR, wdata);
        mask_set     = strobe_if(wr && adr_i == OFS_MASK_SET, wdata);
        mask_clear   = strobe_if(wr && adr_i == OFS_MASK_CLEAR, wdata);
        stop_set     = strobe_if(wr && adr_i == OFS_STOP_SET, wdata);
        stop_clear   = strobe_if(wr && adr_i == OFS_STOP_CLEAR, wdata);
    end

    // ------------------------------------------------------------------
    // match events
    // ------------------------------------------------------------------
    // a unit whose clock is withheld cannot raise a match
    always_comb begin
        match_event                                = '0;
        match_event[CHAN_N-1:0]                    = full_match_i & ~stop_value[CHAN_N-1:0];
        match_event[HALF_LSB +: CHAN_N]            = half_match_i & ~stop_value[CHAN_N-1:0];
        match_event[OS_BIT]                        = os_match_i & ~stop_value[OS_BIT];
    end

    // ------------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------------
    set_clear_bits #(
        .RESET_VAL  (ENABLE_RST),
        .VALID_BITS (ENABLE_BITS)
    ) u_enable (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (enable_set),
        .clear_i (enable_clear),
        .event_i (ZERO_WORD),
        .value_o (enable_value)
    );

    set_clear_bits #(
        .RESET_VAL  (FLAG_RST),
        .VALID_BITS (FLAG_BITS)
    ) u_flag (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (flag_set),
        .clear_i (flag_clear),
        .event_i (match_event),
        .value_o (flag_value)
    );

    set_clear_bits #(
        .RESET_VAL  (MASK_RST),
        .VALID_BITS (FLAG_BITS)
    ) u_mask (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (mask_set),
        .clear_i (mask_clear),
        .event_i (ZERO_WORD),
        .value_o (mask_value)
    );

    set_clear_bits #(
        .RESET_VAL  (STOP_RST),
        .VALID_BITS (STOP_BITS)
    ) u_stop (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (stop_set),
        .clear_i (stop_clear),
        .event_i (ZERO_WORD),
        .value_o (stop_value)
    );

    irq_lines u_irq (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .flags_i (flag_value),
        .mask_i  (mask_value),
        .irq_o   (irq_o)
    );

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // write-only and unmapped addresses answer with zero
    always_comb begin
        if (adr_i == OFS_ENABLE_STATUS) begin
            read_word = {16'h0000, enable_value[ENABLE_W-1:0]};
        end else if (adr_i == OFS_FLAG_STATUS) begin
            read_word = flag_value;
        end else if (adr_i == OFS_MASK_STATUS) begin
            read_word = mask_value;
        end else if (adr_i == OFS_STOP_STATUS) begin
            read_word = stop_value;
        end else begin
            read_word = ZERO_WORD;
        end
    end

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r.bus)
            BUS_IDLE: begin
                if (cyc_i && stb_i) begin
                    state_nxt.bus   = BUS_ACK;
                    state_nxt.ack   = 1'b1;
                    state_nxt.rdata = we_i ? ZERO_WORD : read_word;
                end
            end
            BUS_ACK: begin
                state_nxt.bus = BUS_IDLE;
                state_nxt.ack = 1'b0;
            end
            default: begin
                state_nxt.bus = BUS_IDLE;
                state_nxt.ack = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r.bus   <= BUS_IDLE;
            state_r.ack   <= 1'b0;
            state_r.rdata <= ZERO_WORD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign ack_o                   = state_r.ack;
    assign dat_o                   = state_r.rdata;
    assign chan_count_enable_o     = enable_value[CHAN_N-1:0];
    assign os_timer_count_enable_o = enable_value[OS_BIT];
    // downstream gates each unit's clock and refuses its register access
    assign chan_clock_stop_o       = stop_value[CHAN_N-1:0];
    assign os_timer_clock_stop_o   = stop_value[OS_BIT];
    assign watchdog_clock_stop_o   = stop_value[WDT_BIT];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_ack_single;
        @(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack not a one-cycle answer");

    property p_enable_set;
        @(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == OFS_ENABLE_SET)
            |=> ((enable_value & $past(wdata & ENABLE_BITS)) == $past(wdata & ENABLE_BITS));
    endproperty
    a_enable_set: assert property (p_enable_set) else $error("enable set lost");

    property p_enable_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == OFS_ENABLE_CLEAR) |=> ((enable_value & $past(wdata)) == ZERO_WORD);
    endproperty
    a_enable_clear: assert property (p_enable_clear) else $error("enable clear lost");

    property p_enable_reserved;
        @(posedge clk_i) disable iff (rst_i)
        wr |=> (enable_value[14:6] == 9'h000);
    endproperty
    a_enable_reserved: assert property (p_enable_reserved) else $error("reserved enable bit set");

    property p_full_event;
        @(posedge clk_i) disable iff (rst_i)
        (|(full_match_i & ~stop_value[CHAN_N-1:0]))
            |=> ((flag_value[CHAN_N-1:0] & $past(full_match_i & ~stop_value[CHAN_N-1:0]))
                 == $past(full_match_i & ~stop_value[CHAN_N-1:0]));
    endproperty
    a_full_event: assert property (p_full_event) else $error("full match flag missed");

    property p_os_event_wins;
        @(posedge clk_i) disable iff (rst_i)
        (os_match_i && !stop_value[OS_BIT]) |=> flag_value[OS_BIT];
    endproperty
    a_os_event_wins: assert property (p_os_event_wins) else $error("os match flag missed");

    property p_flag_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == OFS_FLAG_CLEAR && match_event == ZERO_WORD)
            |=> ((flag_value & $past(wdata)) == ZERO_WORD);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear lost");

    property p_mask_reset;
        @(posedge clk_i)
        rst_i |=> (mask_value == MASK_RST && flag_value == FLAG_RST && stop_value == STOP_RST);
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("reset value wrong");

    property p_irq_os;
        @(posedge clk_i) disable iff (rst_i)
        (flag_value[OS_BIT] && !mask_value[OS_BIT]) |=> irq_o[IRQ_OS];
    endproperty
    a_irq_os: assert property (p_irq_os) else $error("os line not raised");

    property p_irq_shared_quiet;
        @(posedge clk_i) disable iff (rst_i)
        ((flag_value & ~mask_value & 32'h001F_001F) == ZERO_WORD) |=> !irq_o[IRQ_SHARED];
    endproperty
    a_irq_shared_quiet: assert property (p_irq_shared_quiet) else $error("shared line spurious");

    property p_stop_set;
        @(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == OFS_STOP_SET)
            |=> ((stop_value & $past(wdata & STOP_BITS)) == $past(wdata & STOP_BITS));
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop set lost");

    property p_read_flags;
        @(posedge clk_i) disable iff (rst_i)
        (state_r.bus == BUS_IDLE && cyc_i && stb_i && !we_i && adr_i == OFS_FLAG_STATUS)
            |=> (dat_o == $past(flag_value));
    endproperty
    a_read_flags: assert property (p_read_flags) else $error("flag read wrong");

    property p_mask_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == OFS_MASK_CLEAR) |=> ((mask_value & $past(wdata)) == ZERO_WORD);
    endproperty
    a_mask_clear: assert property (p_mask_clear) else $error("mask clear lost");

    property p_irq_ch5;
        @(posedge clk_i) disable iff (rst_i)
        (flag_value[CH5_BIT] && !mask_value[CH5_BIT]) |=> irq_o[IRQ_CH5];
    endproperty
    a_irq_ch5: assert property (p_irq_ch5) else $error("channel 5 line not raised");

    property p_stop_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == OFS_STOP_CLEAR) |=> ((stop_value & $past(wdata)) == ZERO_WORD);
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop clear lost");

endmodule : timer_ctrl_regs

//--- rtl/timer_regs_pkg.sv
// constants shared by the timer enable, flag, mask and stop register block
package timer_regs_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int          ADDR_W   = 32;
    localparam int          DATA_W   = 32;
    localparam int          SEL_W    = 4;
    localparam int          CHAN_N   = 6;
    localparam int          IRQ_N    = 3;
    localparam int          ENABLE_W = 16;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] OFS_ENABLE_STATUS = 32'h1000_2010;
    localparam logic [31:0] OFS_ENABLE_SET    = 32'h1000_2014;
    localparam logic [31:0] OFS_ENABLE_CLEAR  = 32'h1000_2018;
    localparam logic [31:0] OFS_STOP_STATUS   = 32'h1000_201C;
    localparam logic [31:0] OFS_FLAG_STATUS   = 32'h1000_2020;
    localparam logic [31:0] OFS_FLAG_SET      = 32'h1000_2024;
    localparam logic [31:0] OFS_FLAG_CLEAR    = 32'h1000_2028;
    localparam logic [31:0] OFS_STOP_SET      = 32'h1000_202C;
    localparam logic [31:0] OFS_MASK_STATUS   = 32'h1000_2030;
    localparam logic [31:0] OFS_MASK_SET      = 32'h1000_2034;
    localparam logic [31:0] OFS_MASK_CLEAR    = 32'h1000_2038;
    localparam logic [31:0] OFS_STOP_CLEAR    = 32'h1000_203C;

    // ------------------------------------------------------------------
    // field layout: implemented bits per register
    // ------------------------------------------------------------------
    localparam logic [31:0] ENABLE_BITS = 32'h0000_803F;
    localparam logic [31:0] FLAG_BITS   = 32'h003F_803F;
    localparam logic [31:0] STOP_BITS   = 32'h0001_803F;
    localparam int          OS_BIT      = 15;
    localparam int          WDT_BIT     = 16;
    localparam int          HALF_LSB    = 16;
    localparam int          CH5_BIT     = 5;
    localparam int          IRQ_OS      = 0;
    localparam int          IRQ_CH5     = 1;
    localparam int          IRQ_SHARED  = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] ENABLE_RST  = 32'h0000_0000;
    localparam logic [31:0] FLAG_RST    = 32'h0000_0000;
    localparam logic [31:0] MASK_RST    = 32'h003F_003F;
    localparam logic [31:0] STOP_RST    = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_type;

endpackage : timer_regs_pkg

//--- rtl/set_clear_bits.sv
// one status word changed only through set, clear and hardware event strobes
`timescale 1ns/1ps
module set_clear_bits
    import timer_regs_pkg::*;
#(
    parameter logic [31:0] RESET_VAL  = 32'h0000_0000,
    parameter logic [31:0] VALID_BITS = 32'hFFFF_FFFF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] set_i,
    input  wire logic [31:0] clear_i,
    input  wire logic [31:0] event_i,
    output logic      [31:0] value_o
);

    typedef struct packed {
        logic [31:0] value;
    } bits_state_type;

    bits_state_type state_r;
    bits_state_type state_nxt;

    // set and event both win over a clear landing in the same cycle
    always_comb begin
        state_nxt       = state_r;
        state_nxt.value = ((state_r.value & ~clear_i) | set_i | event_i) & VALID_BITS;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r.value <= RESET_VAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign value_o = state_r.value;

endmodule : set_clear_bits

//--- rtl/irq_lines.sv
// folds unmasked match flags onto the three interrupt lines
`timescale 1ns/1ps
module irq_lines
    import timer_regs_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [31:0]      flags_i,
    input  wire logic [31:0]      mask_i,
    output logic      [IRQ_N-1:0] irq_o
);

    typedef struct packed {
        logic [IRQ_N-1:0] irq;
    } irq_state_type;

    irq_state_type state_r;
    irq_state_type state_nxt;
    logic [31:0]   pending;

    always_comb begin
        pending                   = flags_i & ~mask_i & FLAG_BITS;
        state_nxt                 = state_r;
        state_nxt.irq[IRQ_OS]     = pending[OS_BIT];
        state_nxt.irq[IRQ_CH5]    = pending[CH5_BIT] | pending[HALF_LSB+CH5_BIT];
        state_nxt.irq[IRQ_SHARED] = (|pending[CH5_BIT-1:0])
                                  | (|pending[HALF_LSB+CH5_BIT-1:HALF_LSB]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r.irq <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign irq_o = state_r.irq;

endmodule : irq_lines

//--- tb/timer_enable_flag_mask_stop_regs_tb_top.sv
// self-checking bench for the timer enable, flag, mask and stop register block
`timescale 1ns/1ps
module timer_enable_flag_mask_stop_regs_tb_top
    import timer_regs_pkg::*;
;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic              clk_i = 1'b0;
    logic              rst_i;
    logic [ADDR_W-1:0] adr_i;
    logic [DATA_W-1:0] dat_i;
    logic [DATA_W-1:0] dat_o;
    logic              we_i;
    logic [SEL_W-1:0]  sel_i;
    logic              stb_i;
    logic              cyc_i;
    logic              ack_o;
    logic [CHAN_N-1:0] half_match_i;
    logic [CHAN_N-1:0] full_match_i;
    logic              os_match_i;
    logic [CHAN_N-1:0] chan_count_enable_o;
    logic              os_timer_count_enable_o;
    logic [CHAN_N-1:0] chan_clock_stop_o;
    logic              os_timer_clock_stop_o;
    logic              watchdog_clock_stop_o;
    logic [IRQ_N-1:0]  irq_o;
    int                err_count;
    int                comparisons;
    int                cycles;
    logic [SEL_W-1:0]  lanes;

    timer_ctrl_regs uut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o),
        .half_match_i(half_match_i), .full_match_i(full_match_i), .os_match_i(os_match_i),
        .chan_count_enable_o(chan_count_enable_o),
        .os_timer_count_enable_o(os_timer_count_enable_o),
        .chan_clock_stop_o(chan_clock_stop_o), .os_timer_clock_stop_o(os_timer_clock_stop_o),
        .watchdog_clock_stop_o(watchdog_clock_stop_o), .irq_o(irq_o)
    );

    always #2.5 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // a hang anywhere lands in the same closing report
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            report_and_stop;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // classic single cycle; read data is taken at the edge that samples ack high
    task bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        adr_i <= a;
        we_i  <= w;
        dat_i <= d;
        sel_i <= lanes;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : bus

    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0000_0000, q);
        check(q, exp);
    endtask : rd

    // lines follow the flags one edge later, so look after the second edge
    task irq_chk(input logic [2:0] exp);
        repeat (2) @(negedge clk_i);
        check({29'h0000_0000, irq_o}, {29'h0000_0000, exp});
    endtask : irq_chk

    task pulse(input logic [5:0] h, input logic [5:0] f, input logic o);
        @(posedge clk_i);
        half_match_i <= h;
        full_match_i <= f;
        os_match_i   <= o;
        @(posedge clk_i);
        half_match_i <= 6'h00;
        full_match_i <= 6'h00;
        os_match_i   <= 1'b0;
    endtask : pulse

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task test_reset_values;
        rd(OFS_ENABLE_STATUS, 32'h0000_0000);
        rd(OFS_FLAG_STATUS, 32'h0000_0000);
        rd(OFS_MASK_STATUS, 32'h003F_003F);
        rd(OFS_STOP_STATUS, 32'h0000_0000);
        check({25'h000_0000, os_timer_count_enable_o, chan_count_enable_o}, 32'h0);
        check({29'h0000_0000, irq_o}, 32'h0000_0000);
    endtask : test_reset_values

    task test_enable;
        wr(OFS_ENABLE_SET, 32'h0000_0000);
        rd(OFS_ENABLE_STATUS, 32'h0000_0000);
        wr(OFS_ENABLE_SET, 32'hFFFF_FFFF);
        @(negedge clk_i);
        check({26'h000_0000, chan_count_enable_o}, 32'h0000_003F);
        check({31'h0000_0000, os_timer_count_enable_o}, 32'h0000_0001);
        rd(OFS_ENABLE_STATUS, 32'h0000_803F);
        rd(OFS_ENABLE_SET, 32'h0000_0000);
        wr(OFS_ENABLE_CLEAR, 32'h0000_4015);
        rd(OFS_ENABLE_STATUS, 32'h0000_802A);
        wr(OFS_ENABLE_CLEAR, 32'h0000_8000);
        rd(OFS_ENABLE_STATUS, 32'h0000_002A);
        wr(OFS_ENABLE_STATUS, 32'hFFFF_FFFF);
        rd(OFS_ENABLE_STATUS, 32'h0000_002A);
        check({26'h000_0000, chan_count_enable_o}, 32'h0000_002A);
        wr(OFS_ENABLE_CLEAR, 32'hFFFF_FFFF);
        rd(OFS_ENABLE_STATUS, 32'h0000_0000);
    endtask : test_enable

    task test_flags;
        pulse(6'h04, 6'h00, 1'b0);
        rd(OFS_FLAG_STATUS, 32'h0004_0000);
        pulse(6'h00, 6'h21, 1'b0);
        rd(OFS_FLAG_STATUS, 32'h0004_0021);
        pulse(6'h00, 6'h00, 1'b1);
        rd(OFS_FLAG_STATUS, 32'h0004_8021);
        wr(OFS_FLAG_SET, 32'hFFFF_FFFF);
        rd(OFS_FLAG_STATUS, 32'h003F_803F);
        wr(OFS_FLAG_CLEAR, 32'h0001_0002);
        rd(OFS_FLAG_STATUS, 32'h003E_803D);
        wr(OFS_FLAG_CLEAR, 32'h0000_0000);
        wr(OFS_FLAG_STATUS, 32'h0000_0000);
        rd(OFS_FLAG_STATUS, 32'h003E_803D);
        wr(OFS_FLAG_CLEAR, 32'hFFFF_FFFF);
        rd(OFS_FLAG_STATUS, 32'h0000_0000);
        lanes = 4'h4;
        wr(OFS_FLAG_SET, 32'hFFFF_FFFF);
        lanes = 4'hF;
        rd(OFS_FLAG_STATUS, 32'h003F_0000);
        wr(OFS_FLAG_CLEAR, 32'hFFFF_FFFF);
        rd(OFS_FLAG_STATUS, 32'h0000_0000);
    endtask : test_flags

    task test_mask_irq;
        wr(OFS_MASK_SET, 32'hFFFF_FFFF);
        rd(OFS_MASK_STATUS, 32'h003F_803F);
        wr(OFS_MASK_CLEAR, 32'h0000_8000);
        rd(OFS_MASK_STATUS, 32'h003F_003F);
        wr(OFS_FLAG_SET, 32'h0000_8000);
        irq_chk(3'b001);
        wr(OFS_MASK_CLEAR, 32'h0000_0020);
        wr(OFS_FLAG_SET, 32'h0000_0021);
        irq_chk(3'b011);
        wr(OFS_MASK_CLEAR, 32'h0001_0000);
        pulse(6'h01, 6'h00, 1'b0);
        irq_chk(3'b111);
        repeat (6) @(posedge clk_i);
        irq_chk(3'b111);
        wr(OFS_MASK_SET, 32'h0000_0020);
        irq_chk(3'b101);
        wr(OFS_FLAG_CLEAR, 32'h0001_8000);
        irq_chk(3'b000);
        wr(OFS_FLAG_CLEAR, 32'hFFFF_FFFF);
        wr(OFS_MASK_SET, 32'h003F_803F);
    endtask : test_mask_irq

    task test_stop;
        wr(OFS_STOP_SET, 32'hFFFF_FFFF);
        rd(OFS_STOP_STATUS, 32'h0001_803F);
        check({26'h000_0000, chan_clock_stop_o}, 32'h0000_003F);
        check({30'h0000_0000, watchdog_clock_stop_o, os_timer_clock_stop_o}, 32'h3);
        pulse(6'h3F, 6'h3F, 1'b1);
        rd(OFS_FLAG_STATUS, 32'h0000_0000);
        wr(OFS_STOP_STATUS, 32'h0000_0000);
        rd(OFS_STOP_STATUS, 32'h0001_803F);
        wr(OFS_STOP_CLEAR, 32'h0001_8001);
        rd(OFS_STOP_STATUS, 32'h0000_003E);
        wr(OFS_STOP_CLEAR, 32'h0000_0000);
        rd(OFS_STOP_STATUS, 32'h0000_003E);
        pulse(6'h01, 6'h01, 1'b1);
        rd(OFS_FLAG_STATUS, 32'h0001_8001);
        rd(32'h1000_2000, 32'h0000_0000);
    endtask : test_stop

    // a second reset in mid-run must bring back every documented reset value
    task test_mid_reset;
        wr(OFS_ENABLE_SET, 32'h0000_803F);
        wr(OFS_MASK_CLEAR, 32'hFFFF_FFFF);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_reset_values;
        check({26'h000_0000, chan_clock_stop_o}, 32'h0000_0000);
    endtask : test_mid_reset

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_i        = 1'b1;
        lanes        = 4'hF;
        adr_i        = 32'h0000_0000;
        dat_i        = 32'h0000_0000;
        we_i         = 1'b0;
        sel_i        = 4'h0;
        stb_i        = 1'b0;
        cyc_i        = 1'b0;
        half_match_i = 6'h00;
        full_match_i = 6'h00;
        os_match_i   = 1'b0;
        err_count    = 0;
        comparisons  = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_reset_values;
        test_enable;
        test_flags;
        test_mask_irq;
        test_stop;
        test_mid_reset;
        report_and_stop;
    end

endmodule : timer_enable_flag_mask_stop_regs_tb_top
